/* hdl/meter_scaling_pkg.sv */
package meter_scaling_pkg;
	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [15:0] DATA_SCALE_SELECT_ADDR = 16'hae3a;
	localparam logic [15:0] DATA_SCALE_SELECT_RST = 16'h0003;
	// ----------------------------------------
	// Demand window limits, minutes
	// ----------------------------------------
	localparam logic [5:0] DEMAND_WIN_MIN = 6'h01;
	localparam logic [5:0] DEMAND_WIN_MAX = 6'h3c;
	localparam logic [5:0] DEMAND_WIN_RST = 6'h0f;
	// ----------------------------------------
	// Phase shift, hundredths of a degree
	// ----------------------------------------
	localparam logic [15:0] PHASE_SHIFT_RST = 16'h006e;
	// ----------------------------------------
	// Indicator timing
	// ----------------------------------------
	localparam int CLK_HZ = 25000000;
	localparam int FLASH_HALF_MS = 100;
	localparam int FLASH_HALF_CYC = CLK_HZ / 1000 * FLASH_HALF_MS;
	localparam int ACT_HOLD_MS = 500;
	localparam int ACT_HOLD_CYC = CLK_HZ / 1000 * ACT_HOLD_MS;
	// ----------------------------------------
	// Wiring and indicator codes
	// ----------------------------------------
	typedef enum logic [1:0] {
		WIRE_WYE = 2'b00,
		WIRE_DELTA = 2'b01,
		WIRE_SINGLE = 2'b10
	} wiring_t;
	typedef enum logic [2:0] {
		IND_GREEN = 3'b000,
		IND_GREEN_FLASH = 3'b001,
		IND_RED = 3'b010,
		IND_RED_FLASH = 3'b011
	} ind_state_t;
	// Scale exponent: factor is ten to the power (exp - 5)
	localparam logic [2:0] EXP_PF = 3'h3;
endpackage

/* hdl/meter_scaling_and_status.sv */
`timescale 1ns/1ps
module meter_scaling_and_status #(
	parameter int FLASH_HALF = meter_scaling_pkg::FLASH_HALF_CYC,
	parameter int ACT_HOLD = meter_scaling_pkg::ACT_HOLD_CYC
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic CE,
	// Register port
	input wire logic REG_WR,
	input wire logic [15:0] REG_ADDR,
	input wire logic [15:0] REG_WDATA,
	output logic [15:0] REG_RDATA,
	output logic REG_HIT,
	// Link mode level and link events, one-cycle pulses
	input wire logic MODBUS_MODE,
	input wire logic EV_OWN_MSG,
	input wire logic EV_OTHER_ADDR,
	input wire logic EV_FAIL,
	input wire logic EV_FOREIGN_PROTO,
	// Indicator
	output logic LINK_STATUS_INDICATOR_GREEN,
	output logic LINK_STATUS_INDICATOR_RED,
	// Configuration
	input wire logic CFG_WR,
	input wire logic [5:0] CFG_DEMAND_WIN,
	input wire logic CFG_LINE_60HZ,
	input wire logic [1:0] CFG_WIRING,
	input wire logic [1:0] CFG_INPUT_SEL,
	input wire logic [15:0] CFG_PHASE_SHIFT,
	output logic [5:0] DEMAND_WIN,
	output logic LINE_60HZ,
	output logic [15:0] PHASE_SHIFT_FIRST,
	output logic [15:0] PHASE_SHIFT_SECOND,
	output logic [15:0] PHASE_SHIFT_THIRD,
	output logic SECOND_INPUT_USED,
	// Demand
	input wire logic MINUTE_TICK,
	input wire logic [31:0] MINUTE_ENERGY,
	output logic [31:0] PEAK_DEMAND,
	// Measurements in base units times 100000
	input wire logic [47:0] RAW_POWER,
	input wire logic [47:0] RAW_PF,
	input wire logic [47:0] RAW_AMPS,
	input wire logic [47:0] RAW_VOLTS,
	output logic [15:0] REG_POWER,
	output logic [15:0] REG_PF,
	output logic [15:0] REG_AMPS,
	output logic [15:0] REG_VOLTS,
	output logic [3:0] REG_OVERFLOW
);
	// ----------------------------------------
	// Scale helpers
	// ----------------------------------------
	function automatic logic [2:0] power_exp(input logic [15:0] code);
		power_exp = (code >= 16'h0006) ? 3'h7 : (code == 16'h0000) ? 3'h0 : 3'(code[2:0] + 3'h1);
	endfunction

	function automatic logic [2:0] amps_exp(input logic [15:0] code);
		amps_exp = (code == 16'h0000) ? 3'h3 : (code <= 16'h0003) ? 3'h4 : 3'h5;
	endfunction

	function automatic logic [2:0] volts_exp(input logic [15:0] code);
		volts_exp = (code <= 16'h0003) ? 3'h4 : 3'h5;
	endfunction

	function automatic logic [47:0] pow10(input logic [2:0] e);
		logic [47:0] p;
		p = 48'h0000_0000_0001;
		for (int i = 0; i < 7; i++) begin
			if (3'(i) < e) begin
				p = 48'(p * 48'h0000_0000_000a);
			end
		end
		pow10 = p;
	endfunction

	// Divide, truncating; overflow flag if above 16 bits
	function automatic logic [16:0] scale(input logic [47:0] raw, input logic [2:0] e);
		logic [47:0] q;
		q = raw / pow10(e);
		scale = (q > 48'h0000_0000_ffff) ? {1'b1, 16'hffff} : {1'b0, q[15:0]};
	endfunction

	// ----------------------------------------
	// Scalar register
	// ----------------------------------------
	logic [15:0] scale_code_r, scale_code_nxt;
	logic hit;

	assign hit = (REG_ADDR == meter_scaling_pkg::DATA_SCALE_SELECT_ADDR);
	assign REG_HIT = hit;

	always_comb begin
		scale_code_nxt = scale_code_r;
		if (REG_WR && hit) begin
			scale_code_nxt = REG_WDATA;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			scale_code_r <= meter_scaling_pkg::DATA_SCALE_SELECT_RST;
		end else if (CE) begin
			scale_code_r <= scale_code_nxt;
		end
	end

	// Unmapped reads return zero
	logic [15:0] rdata_r, rdata_nxt;
	assign rdata_nxt = hit ? scale_code_r : 16'h0000;
	assign REG_RDATA = rdata_r;

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			rdata_r <= 16'h0000;
		end else if (CE) begin
			rdata_r <= rdata_nxt;
		end
	end

	// ----------------------------------------
	// Scaled measurement registers
	// ----------------------------------------
	// Recomputed every cycle, so a code change shows on the next edge
	logic [16:0] s_pw, s_pf, s_am, s_vo;
	logic [63:0] meas_r, meas_nxt;
	logic [3:0] ovf_r, ovf_nxt;

	always_comb begin
		s_pw = scale(RAW_POWER, power_exp(scale_code_r));
		s_pf = scale(RAW_PF, meter_scaling_pkg::EXP_PF);
		s_am = scale(RAW_AMPS, amps_exp(scale_code_r));
		s_vo = scale(RAW_VOLTS, volts_exp(scale_code_r));
		meas_nxt = {s_vo[15:0], s_am[15:0], s_pf[15:0], s_pw[15:0]};
		ovf_nxt = {s_vo[16], s_am[16], s_pf[16], s_pw[16]};
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			meas_r <= 64'h0000_0000_0000_0000;
			ovf_r <= 4'h0;
		end else if (CE) begin
			meas_r <= meas_nxt;
			ovf_r <= ovf_nxt;
		end
	end

	assign REG_POWER = meas_r[15:0];
	assign REG_PF = meas_r[31:16];
	assign REG_AMPS = meas_r[47:32];
	assign REG_VOLTS = meas_r[63:48];
	assign REG_OVERFLOW = ovf_r;

	// ----------------------------------------
	// Configuration
	// ----------------------------------------
	logic [5:0] win_r, win_nxt;
	logic hz60_r, hz60_nxt;
	logic [1:0] wiring_r, wiring_nxt;
	logic [15:0] ps_r [3];
	logic [15:0] ps_nxt [3];

	always_comb begin
		win_nxt = win_r;
		hz60_nxt = hz60_r;
		wiring_nxt = wiring_r;
		ps_nxt = ps_r;
		if (CFG_WR) begin
			// Out-of-range window lengths are ignored
			if (CFG_DEMAND_WIN >= meter_scaling_pkg::DEMAND_WIN_MIN &&
			    CFG_DEMAND_WIN <= meter_scaling_pkg::DEMAND_WIN_MAX) begin
				win_nxt = CFG_DEMAND_WIN;
			end
			hz60_nxt = CFG_LINE_60HZ;
			wiring_nxt = CFG_WIRING;
			unique case (meter_scaling_pkg::wiring_t'(CFG_WIRING))
				meter_scaling_pkg::WIRE_WYE: begin
					if (CFG_INPUT_SEL == 2'h0) begin
						ps_nxt[0] = CFG_PHASE_SHIFT;
						ps_nxt[1] = CFG_PHASE_SHIFT;
						ps_nxt[2] = CFG_PHASE_SHIFT;
					end else if (CFG_INPUT_SEL <= 2'h2) begin
						ps_nxt[CFG_INPUT_SEL] = CFG_PHASE_SHIFT;
					end
				end
				meter_scaling_pkg::WIRE_DELTA: begin
					if (CFG_INPUT_SEL == 2'h0) begin
						ps_nxt[0] = CFG_PHASE_SHIFT;
						ps_nxt[2] = CFG_PHASE_SHIFT;
					end else if (CFG_INPUT_SEL == 2'h1) begin
						ps_nxt[1] = CFG_PHASE_SHIFT;
					end
				end
				default: begin
					if (CFG_INPUT_SEL <= 2'h2) begin
						ps_nxt[CFG_INPUT_SEL] = CFG_PHASE_SHIFT;
					end
				end
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			win_r <= meter_scaling_pkg::DEMAND_WIN_RST;
			hz60_r <= 1'b1;
			wiring_r <= 2'b00;
			for (int i = 0; i < 3; i++) begin
				ps_r[i] <= meter_scaling_pkg::PHASE_SHIFT_RST;
			end
		end else if (CE) begin
			win_r <= win_nxt;
			hz60_r <= hz60_nxt;
			wiring_r <= wiring_nxt;
			ps_r <= ps_nxt;
		end
	end

	assign DEMAND_WIN = win_r;
	assign LINE_60HZ = hz60_r;
	assign PHASE_SHIFT_FIRST = ps_r[0];
	assign PHASE_SHIFT_SECOND = ps_r[1];
	assign PHASE_SHIFT_THIRD = ps_r[2];
	// Single phase leaves the second input idle
	assign SECOND_INPUT_USED = (wiring_r != meter_scaling_pkg::WIRE_SINGLE);

	// ----------------------------------------
	// Peak demand
	// ----------------------------------------
	// History of 60 minute slots; sum uses only the newest win_r
	logic [31:0] hist_r [60];
	logic [31:0] hist_nxt [60];
	logic [31:0] peak_r, peak_nxt;
	logic [37:0] win_sum;
	logic [31:0] win_avg;

	always_comb begin
		hist_nxt = hist_r;
		peak_nxt = peak_r;
		win_sum = 38'h00_0000_0000;
		win_avg = 32'h0000_0000;
		if (MINUTE_TICK) begin
			hist_nxt[0] = MINUTE_ENERGY;
			for (int i = 1; i < 60; i++) begin
				hist_nxt[i] = hist_r[i - 1];
			end
			for (int i = 0; i < 60; i++) begin
				if (6'(i) < win_r) begin
					win_sum = 38'(win_sum + {6'h00, hist_nxt[i]});
				end
			end
			win_avg = 32'(win_sum / {32'h0000_0000, win_r});
			if (win_avg > peak_r) begin
				peak_nxt = win_avg;
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			for (int i = 0; i < 60; i++) begin
				hist_r[i] <= 32'h0000_0000;
			end
			peak_r <= 32'h0000_0000;
		end else if (CE) begin
			hist_r <= hist_nxt;
			peak_r <= peak_nxt;
		end
	end

	assign PEAK_DEMAND = peak_r;

	// ----------------------------------------
	// Link status indicator
	// ----------------------------------------
	meter_scaling_pkg::ind_state_t ind_r, ind_nxt;
	logic [31:0] hold_r, hold_nxt;
	logic [31:0] flash_r, flash_nxt;
	logic phase_r, phase_nxt;

	always_comb begin
		ind_nxt = ind_r;
		hold_nxt = (hold_r != 32'h0000_0000) ? 32'(hold_r - 32'h0000_0001) : hold_r;
		flash_nxt = 32'(flash_r + 32'h0000_0001);
		phase_nxt = phase_r;
		if (flash_r >= 32'(FLASH_HALF - 1)) begin
			flash_nxt = 32'h0000_0000;
			phase_nxt = ~phase_r;
		end
		if (!MODBUS_MODE) begin
			ind_nxt = meter_scaling_pkg::IND_GREEN;
		end else if (EV_FAIL || EV_FOREIGN_PROTO) begin
			ind_nxt = meter_scaling_pkg::IND_RED;
			hold_nxt = 32'(ACT_HOLD);
		end else if (EV_OTHER_ADDR) begin
			ind_nxt = meter_scaling_pkg::IND_RED_FLASH;
			hold_nxt = 32'(ACT_HOLD);
		end else if (EV_OWN_MSG) begin
			ind_nxt = meter_scaling_pkg::IND_GREEN_FLASH;
			hold_nxt = 32'(ACT_HOLD);
		end else if (hold_r == 32'h0000_0000) begin
			ind_nxt = meter_scaling_pkg::IND_GREEN;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			ind_r <= meter_scaling_pkg::IND_GREEN;
			hold_r <= 32'h0000_0000;
			flash_r <= 32'h0000_0000;
			phase_r <= 1'b0;
		end else if (CE) begin
			ind_r <= ind_nxt;
			hold_r <= hold_nxt;
			flash_r <= flash_nxt;
			phase_r <= phase_nxt;
		end
	end

	always_comb begin
		LINK_STATUS_INDICATOR_GREEN = 1'b0;
		LINK_STATUS_INDICATOR_RED = 1'b0;
		unique case (ind_r)
			meter_scaling_pkg::IND_GREEN: LINK_STATUS_INDICATOR_GREEN = 1'b1;
			meter_scaling_pkg::IND_GREEN_FLASH: LINK_STATUS_INDICATOR_GREEN = phase_r;
			meter_scaling_pkg::IND_RED: LINK_STATUS_INDICATOR_RED = 1'b1;
			meter_scaling_pkg::IND_RED_FLASH: LINK_STATUS_INDICATOR_RED = phase_r;
			default: LINK_STATUS_INDICATOR_GREEN = 1'b1;
		endcase
	end
endmodule

/* sim/meter_scaling_and_status_chk.sv */
`timescale 1ns/1ps
module meter_scaling_and_status_chk (
	// Watched ports
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic CE,
	input wire logic REG_WR,
	input wire logic [15:0] REG_ADDR,
	input wire logic [15:0] REG_WDATA,
	input wire logic [15:0] REG_RDATA,
	input wire logic MODBUS_MODE,
	input wire logic EV_FAIL,
	input wire logic LINK_STATUS_INDICATOR_GREEN,
	input wire logic LINK_STATUS_INDICATOR_RED,
	input wire logic CFG_WR,
	input wire logic [5:0] CFG_DEMAND_WIN,
	input wire logic [5:0] DEMAND_WIN,
	input wire logic MINUTE_TICK,
	input wire logic [31:0] PEAK_DEMAND
);
	// ------
	// Helpers
	// ------
	wire logic hit = REG_ADDR == meter_scaling_pkg::DATA_SCALE_SELECT_ADDR;
	wire logic win_ok = CFG_DEMAND_WIN >= meter_scaling_pkg::DEMAND_WIN_MIN
		&& CFG_DEMAND_WIN <= meter_scaling_pkg::DEMAND_WIN_MAX;
	wire logic g = LINK_STATUS_INDICATOR_GREEN;
	wire logic r = LINK_STATUS_INDICATOR_RED;
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RST_N);
	sequence s_wr;
		CE && REG_WR && hit;
	endsequence
	sequence s_fail;
		CE && MODBUS_MODE && EV_FAIL;
	endsequence
	property p_wrrd;
		s_wr ##1 (CE && hit) |=> REG_RDATA == $past(REG_WDATA, 2);
	endproperty
	a_wrrd: assert property (p_wrrd) else $error("code readback wrong");
	property p_rd0;
		CE && !hit |=> REG_RDATA == 16'h0000;
	endproperty
	a_rd0: assert property (p_rd0) else $error("unmapped read not zero");
	property p_hold;
		!(CE && MINUTE_TICK) |=> $stable(PEAK_DEMAND);
	endproperty
	a_hold: assert property (p_hold) else $error("peak moved off tick");
	property p_up;
		CE && MINUTE_TICK |=> PEAK_DEMAND >= $past(PEAK_DEMAND);
	endproperty
	a_up: assert property (p_up) else $error("peak fell");
	property p_win_ign;
		CE && CFG_WR && !win_ok |=> $stable(DEMAND_WIN);
	endproperty
	a_win_ign: assert property (p_win_ign) else $error("bad window taken");
	property p_win_ld;
		CE && CFG_WR && win_ok |=> DEMAND_WIN == $past(CFG_DEMAND_WIN);
	endproperty
	a_win_ld: assert property (p_win_ld) else $error("window not loaded");
	property p_fail;
		s_fail |=> (r && !g || !MODBUS_MODE) [*8];
	endproperty
	a_fail: assert property (p_fail) else $error("fail not steady red");
	property p_idle;
		!MODBUS_MODE |=> g && !r;
	endproperty
	a_idle: assert property (p_idle) else $error("not steady green");
endmodule
bind meter_scaling_and_status meter_scaling_and_status_chk chk (.CLK, .RST_N, .CE, .REG_WR,
	.REG_ADDR, .REG_WDATA, .REG_RDATA, .MODBUS_MODE, .EV_FAIL, .LINK_STATUS_INDICATOR_GREEN,
	.LINK_STATUS_INDICATOR_RED, .CFG_WR, .CFG_DEMAND_WIN, .DEMAND_WIN, .MINUTE_TICK, .PEAK_DEMAND);

/* sim/bus_master_model.sv */
`timescale 1ns/1ps
module bus_master_model (
	// Clock
	input wire logic CLK,
	// Register port
	output logic REG_WR,
	output logic [15:0] REG_ADDR,
	output logic [15:0] REG_WDATA,
	input wire logic [15:0] REG_RDATA,
	// Link events
	output logic [3:0] EV
);
	initial begin
		{REG_WR, REG_ADDR, REG_WDATA, EV} = 37'h0_0000_0000;
	end
	// Address kept so readback follows; data inverted once released
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge CLK) #1 {REG_WR, REG_ADDR, REG_WDATA} = {1'b1, a, d};
		@(posedge CLK) #1 {REG_WR, REG_WDATA} = {1'b0, ~d};
	endtask
	task automatic rd(input logic [15:0] a, output logic [15:0] d);
		@(posedge CLK) #1 REG_ADDR = a;
		@(posedge CLK) #1 d = REG_RDATA;
	endtask
	task automatic pulse(input int i);
		@(posedge CLK) #1 EV[i] = 1'b1;
		@(posedge CLK) #1 EV[i] = 1'b0;
	endtask
endmodule

/* sim/meter_scaling_and_status_tb.sv */
`timescale 1ns/1ps
module meter_scaling_and_status_tb;
	logic CLK = 1'b0;
	logic RST_N = 1'b0;
	logic CFG_WR = 1'b0;
	logic CE = 1'b1;
	logic SECOND_INPUT_USED;
	logic MODBUS_MODE = 1'b1;
	logic CFG_LINE_60HZ = 1'b0;
	logic MINUTE_TICK = 1'b0;
	logic [5:0] CFG_DEMAND_WIN = 6'h02;
	logic [1:0] CFG_WIRING = 2'b00;
	logic [1:0] CFG_INPUT_SEL = 2'b00;
	logic [15:0] CFG_PHASE_SHIFT = 16'h0000;
	logic [31:0] MINUTE_ENERGY = 32'h0000_0000;
	logic [47:0] raw = 48'h0000_00db_ba00;
	logic REG_WR, REG_HIT, LINK_STATUS_INDICATOR_GREEN, LINK_STATUS_INDICATOR_RED, LINE_60HZ;
	logic [15:0] REG_ADDR, REG_WDATA, REG_RDATA, PHASE_SHIFT_FIRST, PHASE_SHIFT_SECOND;
	logic [15:0] PHASE_SHIFT_THIRD, REG_POWER, REG_PF, REG_AMPS, REG_VOLTS, v;
	logic [3:0] ev, REG_OVERFLOW;
	logic [5:0] DEMAND_WIN;
	logic [31:0] PEAK_DEMAND;
	wire logic [1:0] lamp = {LINK_STATUS_INDICATOR_GREEN, LINK_STATUS_INDICATOR_RED};
	wire logic [67:0] meas = {REG_POWER, REG_PF, REG_AMPS, REG_VOLTS, REG_OVERFLOW};
	int mismatches = 0;
	int n_checks = 0;
	int cycles = 0;
	int g, r, t;
	// ------
	// Code, power, pf, amps, volts, overflow for 144 units
	// ------
	logic [83:0] rows [8] = '{{16'h0000, 16'hffff, 16'h3840, 16'h3840, 16'h05a0, 4'h1},
		{16'h0001, 16'hffff, 16'h3840, 16'h05a0, 16'h05a0, 4'h1},
		{16'h0002, 16'h3840, 16'h3840, 16'h05a0, 16'h05a0, 4'h0},
		{16'h0003, 16'h05a0, 16'h3840, 16'h05a0, 16'h05a0, 4'h0},
		{16'h0004, 16'h0090, 16'h3840, 16'h0090, 16'h0090, 4'h0},
		{16'h0005, 16'h000e, 16'h3840, 16'h0090, 16'h0090, 4'h0},
		{16'h0006, 16'h0001, 16'h3840, 16'h0090, 16'h0090, 4'h0},
		{16'h0007, 16'h0001, 16'h3840, 16'h0090, 16'h0090, 4'h0}};
	logic [31:0] en [3] = '{32'h0000_000a, 32'h0000_001e, 32'h0000_0004};
	logic [31:0] pk [3] = '{32'h0000_0005, 32'h0000_0014, 32'h0000_0014};
	always #20 CLK = ~CLK;
	always @(posedge CLK) begin
		cycles <= cycles + 1;
		if (cycles == 1000) begin
			$display("[FAIL] %0t timeout", $time);
			mismatches++;
			give_verdict();
		end
	end
	meter_scaling_and_status #(.FLASH_HALF(4), .ACT_HOLD(20)) dut (.CLK, .RST_N, .CE, .REG_WR,
		.REG_ADDR, .REG_WDATA, .REG_RDATA, .REG_HIT, .MODBUS_MODE, .EV_OWN_MSG(ev[0]),
		.EV_OTHER_ADDR(ev[1]), .EV_FAIL(ev[2]), .EV_FOREIGN_PROTO(ev[3]),
		.LINK_STATUS_INDICATOR_GREEN, .LINK_STATUS_INDICATOR_RED, .CFG_WR, .CFG_DEMAND_WIN,
		.CFG_LINE_60HZ, .CFG_WIRING, .CFG_INPUT_SEL, .CFG_PHASE_SHIFT, .DEMAND_WIN, .LINE_60HZ,
		.PHASE_SHIFT_FIRST, .PHASE_SHIFT_SECOND, .PHASE_SHIFT_THIRD, .SECOND_INPUT_USED,
		.MINUTE_TICK, .MINUTE_ENERGY, .PEAK_DEMAND, .RAW_POWER(raw), .RAW_PF(raw),
		.RAW_AMPS(raw), .RAW_VOLTS(raw), .REG_POWER, .REG_PF, .REG_AMPS, .REG_VOLTS, .REG_OVERFLOW);
	bus_master_model m (.CLK, .REG_WR, .REG_ADDR, .REG_WDATA, .REG_RDATA, .EV(ev));
	task automatic chk(input logic [67:0] got, input logic [67:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic rst();
		@(posedge CLK) #1 RST_N = 1'b0;
		repeat (5) @(posedge CLK);
		#1 RST_N = 1'b1;
	endtask
	task automatic cfg(input logic [5:0] w, input logic [1:0] wi, input logic [1:0] s,
		input logic [15:0] p);
		@(posedge CLK) #1 CFG_WR = 1'b1;
		{CFG_DEMAND_WIN, CFG_WIRING, CFG_INPUT_SEL, CFG_PHASE_SHIFT} = {w, wi, s, p};
		@(posedge CLK) #1 CFG_WR = 1'b0;
	endtask
	task automatic mtick(input logic [31:0] e);
		@(posedge CLK) #1 {MINUTE_TICK, MINUTE_ENERGY} = {1'b1, e};
		@(posedge CLK) #1 {MINUTE_TICK, MINUTE_ENERGY} = {1'b0, ~e};
	endtask
	// Flash phase is free running, so toggles are counted, not matched
	task automatic watch(input int i);
		logic [1:0] p;
		g = 0;
		r = 0;
		t = 0;
		m.pulse(i);
		p = lamp;
		repeat (16) begin
			g += lamp[1] === 1'b1;
			r += lamp[0] === 1'b1;
			t += p !== lamp;
			p = lamp;
			@(posedge CLK) #1;
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		rst();
		foreach (rows[k]) begin
			m.wr(meter_scaling_pkg::DATA_SCALE_SELECT_ADDR, rows[k][83:68]);
			@(posedge CLK) #1;
			chk(meas, rows[k][67:0]);
			m.rd(meter_scaling_pkg::DATA_SCALE_SELECT_ADDR, v);
			chk(v, rows[k][83:68]);
		end
		cfg(6'h02, 2'b00, 2'b00, 16'h00c8);
		chk({DEMAND_WIN, LINE_60HZ, SECOND_INPUT_USED}, {6'h02, 2'b01});
		chk({PHASE_SHIFT_FIRST, PHASE_SHIFT_SECOND, PHASE_SHIFT_THIRD}, {3{16'h00c8}});
		for (int i = 0; i < 3; i++) begin
			mtick(en[i]);
			chk(PEAK_DEMAND, pk[i]);
		end
		cfg(6'h00, 2'b01, 2'b00, 16'h0032);
		chk(DEMAND_WIN, 6'h02);
		chk({PHASE_SHIFT_FIRST, PHASE_SHIFT_SECOND, PHASE_SHIFT_THIRD}, 48'h0032_00c8_0032);
		cfg(6'h3d, 2'b01, 2'b01, 16'h004d);
		chk({DEMAND_WIN, PHASE_SHIFT_SECOND}, {6'h02, 16'h004d});
		cfg(6'h3c, 2'b10, 2'b11, 16'h0000);
		chk({DEMAND_WIN, SECOND_INPUT_USED, PHASE_SHIFT_THIRD}, {6'h3c, 1'b0, 16'h0032});
		for (int i = 0; i < 4; i++) begin
			watch(i);
			chk(i < 2 ? {(i ? g : r) == 0, t > 2} : {r == 16, g + t == 0}, 2'b11);
			repeat (12) @(posedge CLK);
			#1 chk(lamp, 2'b10);
		end
		MODBUS_MODE = 1'b0;
		watch(2);
		chk({g == 16, r == 0}, 2'b11);
		rst();
		m.rd(meter_scaling_pkg::DATA_SCALE_SELECT_ADDR, v);
		chk(v, meter_scaling_pkg::DATA_SCALE_SELECT_RST);
		chk(PHASE_SHIFT_THIRD, meter_scaling_pkg::PHASE_SHIFT_RST);
		chk(DEMAND_WIN, meter_scaling_pkg::DEMAND_WIN_RST);
		chk({LINE_60HZ, PEAK_DEMAND}, 33'h1_0000_0000);
		m.wr(16'hae3b, 16'h0005);
		m.rd(meter_scaling_pkg::DATA_SCALE_SELECT_ADDR, v);
		chk(v, meter_scaling_pkg::DATA_SCALE_SELECT_RST);
		chk(REG_HIT, 1'b1);
		m.rd(16'hae3b, v);
		chk(v, 16'h0000);
		chk(REG_HIT, 1'b0);
		// Enable low must freeze code and peak
		CE = 1'b0;
		m.wr(meter_scaling_pkg::DATA_SCALE_SELECT_ADDR, 16'h0005);
		mtick(32'h0000_0064);
		chk(PEAK_DEMAND, 32'h0000_0000);
		CE = 1'b1;
		m.rd(meter_scaling_pkg::DATA_SCALE_SELECT_ADDR, v);
		chk(v, meter_scaling_pkg::DATA_SCALE_SELECT_RST);
		give_verdict();
	end
endmodule
